// file: shared/scg_pkg.sv
package scg_pkg;
	// register indices on the software port
	localparam logic [3:0] REG_PIN_MODE = 4'h0;
	localparam logic [3:0] REG_RUN_CTL = 4'h1;
	localparam logic [3:0] REG_SETTLE_STAT = 4'h2;
	localparam logic [3:0] REG_SETTLE_SEL = 4'h3;
	localparam logic [3:0] REG_CLK_SEL = 4'h4;
	localparam logic [3:0] REG_PERIPH_GATE = 4'h5;
	localparam logic [3:0] REG_FLASH_SPEED = 4'h6;
	localparam logic [3:0] REG_TRIM = 4'h7;
	localparam logic [3:0] REG_TTBL_HIGH = 4'h8;
	localparam logic [3:0] REG_TTBL_LOW = 4'h9;
	// pin mode fields
	localparam int PM_MAIN_OSC = 7;
	localparam int PM_MAIN_EXT = 6;
	localparam int PM_SUB_OSC = 4;
	// run control fields
	localparam int RC_MAIN_STOP = 7;
	localparam int RC_SUB_STOP = 6;
	localparam int RC_FAST_STOP = 0;
	// clock select fields: request in [1:0], active in [5:4]
	localparam int CS_ACT_LSB = 4;
	// reset values
	localparam logic [7:0] PIN_MODE_RST = 8'h00;
	localparam logic [7:0] RUN_CTL_RST = 8'hc0;
	localparam logic [2:0] SETTLE_SEL_RST = 3'h7;
	localparam logic [7:0] PERIPH_GATE_RST = 8'h00;
	localparam logic [7:0] FLASH_SPEED_RST = 8'h00;
	localparam logic [7:0] TRIM_RST = 8'h10;
	// factory table contents, arbitrary neutral values
	localparam logic [7:0] TTBL_HIGH_VAL = 8'h5a;
	localparam logic [7:0] TTBL_LOW_VAL = 8'ha5;
	// settle time: 2^(SETTLE_BASE + select) main oscillator cycles
	localparam int SETTLE_BASE = 8;
	localparam logic [15:0] SETTLE_MAX = 16'hffff;
	// cpu clock sources; the slow internal oscillator has no code
	typedef enum logic [1:0] {
		SRC_FAST = 2'b00,
		SRC_MAIN = 2'b01,
		SRC_SUB = 2'b10
	} scg_src_t;
	localparam scg_src_t SRC_RST = SRC_FAST;
	// switch sequencer
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_OLD = 2'b01,
		SW_NEW = 2'b10
	} scg_sw_t;
endpackage

// file: test/scg_osc_model.sv
`timescale 1ns/100ps
// oscillators and external clock source on the far side of the pins
module scg_osc_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_fast_en,
	input wire logic i_main_en,
	input wire logic i_sub_en,
	input wire logic i_slow_en,
	output logic o_fast_tick,
	output logic o_main_tick,
	output logic o_ext_tick,
	output logic o_sub_tick,
	output logic o_slow_tick
);
	logic [3:0] cnt_q;
	// free running divider shared by every source
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
	end
	// a stopped oscillator makes no ticks at all
	assign o_fast_tick = i_fast_en & cnt_q[0];
	assign o_main_tick = i_main_en & (cnt_q[1:0] == 2'h3);
	assign o_ext_tick = (cnt_q[1:0] == 2'h1); // external source runs free
	assign o_sub_tick = i_sub_en & (cnt_q == 4'hf);
	assign o_slow_tick = i_slow_en & (cnt_q[2:0] == 3'h5);
endmodule

// file: test/tb_scg_clock_gen.sv
`timescale 1ns/100ps
module tb_scg_clock_gen
	import scg_pkg::*;
;
	logic i_mclk, i_reset_n, i_wr_stb, i_rd_stb, i_opt_slow_osc_en, i_deep_halt;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, o_rdata, o_periph_clk_en, o_fast_trim, rd;
	logic i_fast_tick, i_main_tick, i_ext_tick, i_sub_tick, i_slow_tick;
	logic o_main_osc_en, o_main_pins_port, o_sub_osc_en, o_sub_pins_port;
	logic o_fast_osc_en, o_slow_osc_en, o_wdt_clk_en, o_cpu_clk_en;
	logic o_cpu_hold, o_flash_boost;
	int fails, checked;
	logic [3:0] rst_addr [8] = '{REG_PIN_MODE, REG_RUN_CTL, REG_PERIPH_GATE,
		REG_FLASH_SPEED, REG_TRIM, REG_TTBL_HIGH, REG_TTBL_LOW, 4'ha};
	logic [7:0] rst_val [8] = '{PIN_MODE_RST, RUN_CTL_RST, PERIPH_GATE_RST,
		FLASH_SPEED_RST, TRIM_RST, TTBL_HIGH_VAL, TTBL_LOW_VAL, 8'h00};

	scg_clock_gen i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr_stb(i_wr_stb),
		.i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_fast_tick(i_fast_tick),
		.i_main_tick(i_main_tick), .i_ext_tick(i_ext_tick),
		.i_sub_tick(i_sub_tick), .i_slow_tick(i_slow_tick),
		.i_opt_slow_osc_en(i_opt_slow_osc_en), .i_deep_halt(i_deep_halt),
		.o_main_osc_en(o_main_osc_en), .o_main_pins_port(o_main_pins_port),
		.o_sub_osc_en(o_sub_osc_en), .o_sub_pins_port(o_sub_pins_port),
		.o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en),
		.o_wdt_clk_en(o_wdt_clk_en), .o_cpu_clk_en(o_cpu_clk_en),
		.o_cpu_hold(o_cpu_hold), .o_periph_clk_en(o_periph_clk_en),
		.o_flash_boost(o_flash_boost), .o_fast_trim(o_fast_trim));

	scg_osc_model i_osc (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_fast_en(o_fast_osc_en), .i_main_en(o_main_osc_en),
		.i_sub_en(o_sub_osc_en), .i_slow_en(o_slow_osc_en),
		.o_fast_tick(i_fast_tick), .o_main_tick(i_main_tick),
		.o_ext_tick(i_ext_tick), .o_sub_tick(i_sub_tick),
		.o_slow_tick(i_slow_tick));

	// 200 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	task automatic end_sim();
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr_stb <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr_stb <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rdr(input logic [3:0] a);
		@(posedge i_mclk);
		i_rd_stb <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd_stb <= 1'b0;
		#1 rd = o_rdata;
	endtask

	task automatic do_reset();
		@(posedge i_mclk);
		i_reset_n <= 1'b0;
		repeat (20) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		repeat (2) @(posedge i_mclk);
	endtask

	task automatic t_reset();
		int n;
		for (int k = 0; k < 8; k++) begin
			rdr(rst_addr[k]);
			chk(rd, rst_val[k]);
		end
		rdr(REG_SETTLE_SEL);
		chk(rd[2:0], SETTLE_SEL_RST);
		rdr(REG_CLK_SEL);
		chk({rd[5:4], rd[1:0]}, {SRC_FAST, SRC_FAST});
		chk({o_fast_osc_en, o_main_pins_port, o_sub_pins_port}, 3'h7);
		chk(o_slow_osc_en, 1'b1);
		n = 0;
		while (o_cpu_clk_en !== 1'b1 && n < 50) begin
			@(posedge i_mclk);
			#1 n++;
		end
		chk(n < 50, 1'b1);
	endtask

	task automatic t_regs();
		int n;
		wr(REG_TRIM, 8'h55);
		chk(o_fast_trim, 8'h55);
		rdr(REG_TRIM);
		chk(rd, 8'h55);
		wr(REG_FLASH_SPEED, 8'h01);
		chk(o_flash_boost, 1'b1);
		wr(REG_TTBL_HIGH, 8'h00);
		rdr(REG_TTBL_HIGH);
		chk(rd, TTBL_HIGH_VAL);
		wr(REG_PERIPH_GATE, 8'h05);
		n = 0;
		repeat (20) begin
			@(posedge i_mclk);
			#1 chk(o_periph_clk_en, o_cpu_clk_en ? 8'h05 : 8'h00);
			n += o_cpu_clk_en;
		end
		chk(n > 0, 1'b1);
	endtask

	task automatic t_pins();
		wr(REG_PIN_MODE, 8'h90);
		chk({o_main_pins_port, o_sub_pins_port, o_main_osc_en}, 3'h0);
		wr(REG_RUN_CTL, 8'h00);
		chk({o_main_osc_en, o_sub_osc_en, o_slow_osc_en}, 3'h7);
		repeat (16) begin
			@(posedge i_mclk);
			#1 chk(o_wdt_clk_en, i_slow_tick);
		end
	endtask

	task automatic t_switch();
		int n;
		wr(REG_SETTLE_SEL, 8'h00);
		@(posedge i_mclk);
		i_deep_halt <= 1'b1;
		repeat (10) @(posedge i_mclk);
		i_deep_halt <= 1'b0;
		rdr(REG_SETTLE_STAT);
		chk(rd[0], 1'b0);
		n = 0;
		while (rd[0] !== 1'b1 && n < 1000) begin
			rdr(REG_SETTLE_STAT);
			n++;
		end
		chk(rd[0], 1'b1);
		chk(n > 400, 1'b1);
		wr(REG_CLK_SEL, 8'h01);
		n = 0;
		rd = 8'h00;
		while (rd[5:4] !== SRC_MAIN && n < 40) begin
			rdr(REG_CLK_SEL);
			n++;
		end
		chk({rd[5:4], rd[1:0]}, {SRC_MAIN, SRC_MAIN});
		wr(REG_CLK_SEL, 8'h03);
		rdr(REG_CLK_SEL);
		chk({rd[5:4], rd[1:0]}, {SRC_MAIN, SRC_MAIN});
		wr(REG_RUN_CTL, 8'h80);
		rdr(REG_RUN_CTL);
		chk({rd[7], o_main_osc_en}, 2'h1);
	endtask

	// deep halt release on the main crystal holds the cpu for 2^8 ticks
	task automatic t_halt();
		int n, ticks;
		wr(REG_SETTLE_SEL, 8'h00);
		@(posedge i_mclk);
		i_deep_halt <= 1'b1;
		repeat (10) @(posedge i_mclk);
		i_deep_halt <= 1'b0;
		@(posedge i_mclk);
		#1 chk(o_cpu_hold, 1'b1);
		n = 0;
		ticks = 0;
		while (o_cpu_hold === 1'b1 && n < 2000) begin
			chk(o_cpu_clk_en, 1'b0);
			ticks += i_main_tick;
			@(posedge i_mclk);
			#1 n++;
		end
		chk(ticks >= 254 && ticks <= 258, 1'b1);
		rdr(REG_SETTLE_STAT);
		chk(rd[0], 1'b1);
	endtask

	initial begin
		fails = 0;
		checked = 0;
		i_reset_n = 1'b0;
		i_wr_stb = 1'b0;
		i_rd_stb = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_opt_slow_osc_en = 1'b1;
		i_deep_halt = 1'b0;
		do_reset();
		t_reset();
		t_regs();
		t_pins();
		t_switch();
		t_halt();
		do_reset();
		rdr(REG_CLK_SEL);
		chk({rd[5:4], rd[1:0]}, {SRC_FAST, SRC_FAST});
		end_sim();
	end
endmodule

// file: verilog/scg_clock_gen.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module scg_clock_gen
	import scg_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [7:0] o_rdata,
	input wire logic i_fast_tick,
	input wire logic i_main_tick,
	input wire logic i_ext_tick,
	input wire logic i_sub_tick,
	input wire logic i_slow_tick,
	input wire logic i_opt_slow_osc_en,
	input wire logic i_deep_halt,
	output logic o_main_osc_en,
	output logic o_main_pins_port,
	output logic o_sub_osc_en,
	output logic o_sub_pins_port,
	output logic o_fast_osc_en,
	output logic o_slow_osc_en,
	output logic o_wdt_clk_en,
	output logic o_cpu_clk_en,
	output logic o_cpu_hold,
	output logic [7:0] o_periph_clk_en,
	output logic o_flash_boost,
	output logic [7:0] o_fast_trim
);
	logic [7:0] pin_mode_q;
	logic [7:0] run_ctl_q;
	logic [2:0] settle_sel_q;
	logic [7:0] periph_q;
	logic [7:0] flash_q;
	logic [7:0] trim_q;
	logic [1:0] req_q;
	scg_src_t act_q;
	scg_src_t tgt_q;
	scg_sw_t sw_q;
	logic [15:0] settle_q;
	logic main_run_q;
	logic halt_q;
	logic wait_q;
	logic strap_done_q;
	logic slow_en_q;
	logic cpu_en_q;
	logic [7:0] periph_en_q;
	logic [7:0] rdata_q;

	// tick of a given source; selecting the slow oscillator is impossible
	function automatic logic src_tick(input scg_src_t s, input logic f,
		input logic m, input logic b);
		case (s)
			SRC_FAST: src_tick = f;
			SRC_MAIN: src_tick = m;
			SRC_SUB: src_tick = b;
			default: src_tick = 1'b0;
		endcase
	endfunction

	// source running state
	function automatic logic src_run(input scg_src_t s, input logic f,
		input logic m, input logic b);
		case (s)
			SRC_FAST: src_run = f;
			SRC_MAIN: src_run = m;
			SRC_SUB: src_run = b;
			default: src_run = 1'b0;
		endcase
	endfunction

	// settle count reached for a select value
	function automatic logic settle_hit(input logic [15:0] c,
		input logic [2:0] sel);
		settle_hit = ({1'b0, c} >= (17'h1 << (SETTLE_BASE + sel)));
	endfunction

	// run control stop bit that belongs to a source
	function automatic logic [7:0] src_keep(input scg_src_t s);
		case (s)
			SRC_FAST: src_keep = 8'h01;
			SRC_MAIN: src_keep = 8'h80;
			SRC_SUB: src_keep = 8'h40;
			default: src_keep = 8'h00;
		endcase
	endfunction

	// bus decode
	wire wr_pin = i_wr_stb && (i_addr == REG_PIN_MODE);
	wire wr_run = i_wr_stb && (i_addr == REG_RUN_CTL);
	wire wr_sel = i_wr_stb && (i_addr == REG_SETTLE_SEL);
	wire wr_clk = i_wr_stb && (i_addr == REG_CLK_SEL);
	wire wr_per = i_wr_stb && (i_addr == REG_PERIPH_GATE);
	wire wr_fls = i_wr_stb && (i_addr == REG_FLASH_SPEED);
	wire wr_trm = i_wr_stb && (i_addr == REG_TRIM);

	// pin pair use and source selection of the main clock
	wire main_osc_mode = pin_mode_q[PM_MAIN_OSC];
	wire main_ext_mode = pin_mode_q[PM_MAIN_EXT] && !main_osc_mode;
	wire sub_osc_mode = pin_mode_q[PM_SUB_OSC];
	wire main_tick = main_ext_mode ? i_ext_tick : i_main_tick;

	// running sources from run control, slow oscillator excluded
	wire fast_run = !run_ctl_q[RC_FAST_STOP];
	wire xtal_run = main_osc_mode && !run_ctl_q[RC_MAIN_STOP];
	wire main_run = xtal_run || (main_ext_mode && !run_ctl_q[RC_MAIN_STOP]);
	wire sub_run = sub_osc_mode && !run_ctl_q[RC_SUB_STOP];

	// settle counter events
	wire halt_release = halt_q && !i_deep_halt;
	wire settle_restart = (xtal_run && !main_run_q) ||
		(halt_release && xtal_run);
	wire settle_done = settle_hit(settle_q, settle_sel_q);
	wire [15:0] settle_d = (!xtal_run || settle_restart) ? 16'h0000 :
		(i_main_tick && !i_deep_halt && settle_q != SETTLE_MAX) ?
		settle_q + 16'h0001 : settle_q;

	// settle status thermometer
	logic [7:0] settle_stat;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stat
			assign settle_stat[gi] = settle_hit(settle_q, 3'(gi));
		end
	endgenerate

	// switch sequencer next values
	scg_src_t req_src;
	assign req_src = (req_q == 2'b01) ? SRC_MAIN :
		(req_q == 2'b10) ? SRC_SUB : SRC_FAST;
	wire act_tick = src_tick(act_q, i_fast_tick, main_tick, i_sub_tick);
	wire tgt_tick = src_tick(tgt_q, i_fast_tick, main_tick, i_sub_tick);
	wire tgt_ok = src_run(req_src, fast_run, main_run, sub_run);
	scg_sw_t sw_d;
	assign sw_d = (sw_q == SW_IDLE && req_src != act_q && tgt_ok) ? SW_OLD :
		(sw_q == SW_OLD && act_tick) ? SW_NEW :
		(sw_q == SW_NEW && tgt_tick) ? SW_IDLE : sw_q;
	wire sw_done = (sw_q == SW_NEW) && tgt_tick;

	// run control writes stop neither the active source nor a switch target
	scg_src_t keep_src;
	assign keep_src = (sw_q == SW_IDLE) ? req_src : tgt_q;
	wire keep_tgt = (sw_q != SW_IDLE) || tgt_ok;
	wire [7:0] run_keep = src_keep(act_q) |
		(keep_tgt ? src_keep(keep_src) : 8'h00);
	wire [7:0] run_ctl_d = wr_run ? (i_wdata & ~run_keep) | (run_ctl_q &
		run_keep) : run_ctl_q;

	// cpu hold while main crystal settles after deep halt
	wire hold = wait_q && (act_q == SRC_MAIN) && !main_ext_mode;
	wire wait_d = (halt_release && xtal_run) ? 1'b1 :
		(settle_done ? 1'b0 : wait_q);
	// no cpu pulse in the cycle that arms the hold either
	wire hold_d = wait_d && (act_q == SRC_MAIN) && !main_ext_mode;
	wire cpu_gate = (sw_q == SW_IDLE) && act_tick && !hold && !hold_d;

	// read mux
	logic [7:0] rd_mux;
	assign rd_mux =
		(i_addr == REG_PIN_MODE) ? pin_mode_q :
		(i_addr == REG_RUN_CTL) ? run_ctl_q :
		(i_addr == REG_SETTLE_STAT) ? settle_stat :
		(i_addr == REG_SETTLE_SEL) ? {5'h00, settle_sel_q} :
		(i_addr == REG_CLK_SEL) ? {2'b00, act_q, 2'b00, req_q} :
		(i_addr == REG_PERIPH_GATE) ? periph_q :
		(i_addr == REG_FLASH_SPEED) ? flash_q :
		(i_addr == REG_TRIM) ? trim_q :
		(i_addr == REG_TTBL_HIGH) ? TTBL_HIGH_VAL :
		(i_addr == REG_TTBL_LOW) ? TTBL_LOW_VAL : 8'h00;

	// software registers
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_mode_q <= PIN_MODE_RST;
			run_ctl_q <= RUN_CTL_RST;
			settle_sel_q <= SETTLE_SEL_RST;
			req_q <= SRC_RST;
			periph_q <= PERIPH_GATE_RST;
			flash_q <= FLASH_SPEED_RST;
			trim_q <= TRIM_RST;
			rdata_q <= 8'h00;
		end else begin
			if (wr_pin)
				pin_mode_q <= i_wdata;
			run_ctl_q <= run_ctl_d;
			if (wr_sel)
				settle_sel_q <= i_wdata[2:0];
			if (wr_clk && i_wdata[1:0] != 2'b11)
				req_q <= i_wdata[1:0];
			if (wr_per)
				periph_q <= i_wdata;
			if (wr_fls)
				flash_q <= i_wdata;
			if (wr_trm)
				trim_q <= i_wdata;
			rdata_q <= i_rd_stb ? rd_mux : 8'h00;
		end
	end

	// source switch and active status
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sw_q <= SW_IDLE;
			act_q <= SRC_RST;
			tgt_q <= SRC_RST;
		end else begin
			sw_q <= sw_d;
			if (sw_q == SW_IDLE)
				tgt_q <= req_src;
			if (sw_done)
				act_q <= tgt_q;
		end
	end

	// settle counter and deep halt tracking
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			settle_q <= 16'h0000;
			main_run_q <= 1'b0;
			halt_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			settle_q <= settle_d;
			main_run_q <= xtal_run;
			halt_q <= i_deep_halt;
			wait_q <= wait_d;
		end
	end

	// option strap caught once after reset release
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strap_done_q <= 1'b0;
			slow_en_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			slow_en_q <= i_opt_slow_osc_en;
		end
	end

	// gated clock enables, whole source pulses only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cpu_en_q <= 1'b0;
			periph_en_q <= 8'h00;
		end else begin
			cpu_en_q <= cpu_gate;
			periph_en_q <= {8{cpu_gate}} & periph_q;
		end
	end

	// outputs
	assign o_rdata = rdata_q;
	assign o_main_osc_en = xtal_run;
	assign o_main_pins_port = !main_osc_mode && !pin_mode_q[PM_MAIN_EXT];
	assign o_sub_osc_en = sub_run;
	assign o_sub_pins_port = !sub_osc_mode;
	assign o_fast_osc_en = fast_run;
	assign o_slow_osc_en = slow_en_q;
	assign o_wdt_clk_en = slow_en_q && i_slow_tick;
	assign o_cpu_clk_en = cpu_en_q;
	assign o_cpu_hold = hold;
	assign o_periph_clk_en = periph_en_q;
	assign o_flash_boost = flash_q[0];
	assign o_fast_trim = trim_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	sequence s_switch_start;
		sw_q == SW_IDLE ##1 sw_q == SW_OLD;
	endsequence
	sequence s_gap;
		!o_cpu_clk_en [*2];
	endsequence

	a_active_legal: assert property (act_q != 2'b11)
		else $error("active source took the slow oscillator code");
	a_switch_change: assert property ($changed(act_q) |->
		$past(sw_q) == SW_NEW)
		else $error("active source changed outside the switch end");
	a_switch_gap: assert property (s_switch_start |=> s_gap)
		else $error("cpu clock pulsed during a source switch");
	a_periph_gate: assert property (periph_q == 8'h00 |=>
		o_periph_clk_en == 8'h00)
		else $error("peripheral clock without gate");
	a_select_read: assert property (i_rd_stb && i_addr == REG_CLK_SEL |=>
		o_rdata[5:4] == $past(act_q))
		else $error("clock select read lost active source");
	a_hold_source: assert property (o_cpu_hold |->
		act_q == SRC_MAIN && !o_cpu_clk_en)
		else $error("cpu held off the main source or clock leaked");
	a_hold_release: assert property (wait_q && settle_done &&
		!(halt_release && xtal_run) |=> !o_cpu_hold)
		else $error("cpu hold kept after settle time");
	a_strap_fixed: assert property (strap_done_q |=>
		$stable(slow_en_q))
		else $error("slow oscillator run changed after startup");
	a_trim_write: assert property (wr_trm |=> o_fast_trim ==
		$past(i_wdata))
		else $error("trim write not taken");
	a_settle_restart: assert property (xtal_run && !main_run_q |=>
		settle_q == 16'h0000 || settle_q == 16'h0001)
		else $error("settle count not restarted on main start");
	a_keep_active: assert property (wr_run && act_q == SRC_FAST |=>
		o_fast_osc_en)
		else $error("active fast oscillator was stopped");
	a_cpu_tick: assert property (o_cpu_clk_en |-> $past(act_tick))
		else $error("cpu pulse without active source tick");
endmodule
